/* File: rtl/lbft_pkg.sv */
// shared constants and carrier types for the layer bus frame timing block
package lbft_pkg;

  // operating modes from the straps
  localparam logic [1:0] MODE_TE  = 2'h0;
  localparam logic [1:0] MODE_LTT = 2'h1;
  localparam logic [1:0] MODE_LTS = 2'h2;
  localparam logic [1:0] MODE_NT  = 2'h3;

  // clock rates
  localparam int SYS_KHZ      = 10000;
  localparam int DCLK_GEN1_KHZ = 512;
  localparam int DCLK_TE2_KHZ = 1536;
  localparam int DCLK_LT2_KHZ = 4096;
  localparam int AUX_TE2_KHZ  = 768;
  localparam int AUX_LTT2_KHZ = 512;
  localparam int PORT_A_CLK_KHZ = 128;
  localparam int ZERO_CONT_KHZ = 96;
  localparam int ZERO_SINGLE_KHZ = 2;
  localparam int FRAME_KHZ    = 8;

  // derived counts
  localparam int CLKS_PER_CH  = DCLK_GEN1_KHZ / FRAME_KHZ;
  localparam logic [3:0] AUX_TE2_HALF  = 4'(DCLK_TE2_KHZ / (2 * AUX_TE2_KHZ));
  localparam logic [3:0] AUX_LTT2_HALF = 4'(DCLK_LT2_KHZ / (2 * AUX_LTT2_KHZ));
  localparam int PORT_A_CLK_BIT = $clog2(DCLK_GEN1_KHZ / PORT_A_CLK_KHZ) - 1;
  localparam int ZERO_CONT_CYCLES   = SYS_KHZ / ZERO_CONT_KHZ;
  localparam int ZERO_SINGLE_CYCLES = SYS_KHZ / ZERO_SINGLE_KHZ;

  // frame layout
  localparam logic [3:0] CH_GEN1     = 4'h1;
  localparam logic [3:0] CH_TERMINAL = 4'h3;
  localparam logic [3:0] CH_NONTERM  = 4'h8;
  localparam logic [4:0] ECHO_POS_HI = 5'h18;
  localparam logic [4:0] ECHO_POS_LO = 5'h19;
  localparam logic [4:0] MBIT_POS    = 5'h1A;
  localparam int STOPGO_IDX          = 4;
  localparam logic [7:0] IDLE_OCTET  = 8'hFF;
  localparam logic [3:0] CI_DISCONNECT = 4'h0;
  localparam logic [8:0] DLY_SYNC_START = 9'h010;
  localparam logic [8:0] DLY_SYNC_WIDTH = 9'h002;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic [1:0] mode;
    logic       gen2;
    logic       timingSel;
    logic [1:0] fsPolarity;
  } lbft_cfg_t;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] mon;
    logic [1:0] d;
    logic [3:0] ci;
    logic [1:0] echoE;
    logic       mBit;
    logic [1:0] upD;
    logic [3:0] upCi;
  } lbft_tx_t;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] mon;
    logic [1:0] d;
    logic [3:0] ci;
  } lbft_rx_t;

  typedef enum logic [2:0] {
    ACT_IDLE  = 3'b001,
    ACT_INFO1 = 3'b010,
    ACT_UP    = 3'b100
  } lbft_act_t;

endpackage

/* File: rtl/lbft_sync.sv */
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
`default_nettype none
module lbft_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // level in, synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= '0;
      q       <= '0;
    end else begin
      stage_r <= d;
      q       <= stage_r;
    end
  end
endmodule // lbft_sync
`default_nettype wire

/* File: rtl/lbft_frame_timing.sv */
// frame timing, activation gating and data ports of the layer bus
`timescale 1ns/100ps
`default_nettype none
module lbft_frame_timing
  import lbft_pkg::*;
#(
  parameter bit HAS_CONNECT_PIN      = 1'b1,
  parameter int SINGLE_ZERO_CYCLES   = ZERO_SINGLE_CYCLES
) (
  // system clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // straps and asynchronous pins
  input  wire logic       modeStrapHigh,
  input  wire logic       modeStrapLow,
  input  wire logic       sBusConnectedIn,
  input  wire logic       sendContZerosIn,
  input  wire logic       sendSingleZerosIn,
  // configuration
  input  wire logic       interfaceModeSelect,
  input  wire logic       serialPortTimingSelect,
  input  wire logic [1:0] frameSyncPolarity,
  input  wire logic [1:0] b1RouteSelect,
  input  wire logic [1:0] b2RouteSelect,
  // activation
  input  wire logic       activateRequest,
  input  wire logic       rxInfo2or4,
  // outgoing frame content
  input  wire logic [7:0] b1TxData,
  input  wire logic [7:0] b2TxData,
  input  wire logic       monitorEnable,
  input  wire logic [7:0] monitorTxData,
  input  wire logic       arbitrationAccess,
  input  wire logic       dChannelStopGo,
  input  wire logic [1:0] dTxBits,
  input  wire logic [3:0] ciTxCode,
  input  wire logic [1:0] echoBitsIn,
  input  wire logic       multiframeBitIn,
  input  wire logic [1:0] upDTxBits,
  input  wire logic [3:0] upCiTxCode,
  // status towards the system
  output logic [1:0]      operatingMode,
  output logic            sendInfo1,
  output logic            activated,
  output logic            disconnectIndication,
  output logic            sendZerosActive,
  output logic            sendZeroStrobe,
  output logic            pingPongEnable,
  output logic            pingPongMaster,
  output logic            syncPortEnable,
  output lbft_rx_t        rxFrame,
  output logic            rxFrameValid,
  // link pins, bus data clock domain
  input  wire logic       busDataClock,
  input  wire logic       frameSyncOneIn,
  input  wire logic       frameSyncTwoIn,
  input  wire logic       upstreamIn,
  output logic            busClockOe,
  output logic            frameSyncOneOut,
  output logic            frameSyncTwoOut,
  output logic            frameSyncOe,
  output logic            downstreamOut,
  output logic            downstreamOe,
  output logic            upstreamOut,
  output logic            upstreamOe,
  output logic            echoOut,
  output logic            echoOe,
  output logic            auxClockOut,
  output logic            auxClockOe,
  output logic            serialPortAOut,
  output logic            serialPortAOe,
  output logic            downstreamPullup,
  output logic            upstreamPullup
);

  // ---------------- system domain ----------------
  logic [1:0] strapSync;
  logic       connSync;
  logic [1:0] zeroSync;
  logic [1:0] strapWait_r;
  logic [1:0] mode_r;

  lbft_sync #(.WIDTH(5)) uPinSync (
    .clk   (clk_sys),
    .rst_n (reset_n),
    .d     ({modeStrapHigh, modeStrapLow, sBusConnectedIn, sendContZerosIn, sendSingleZerosIn}),
    .q     ({strapSync, connSync, zeroSync})
  );

  // straps are caught once the synchroniser has settled after release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strapWait_r <= '0;
      mode_r      <= MODE_TE;
    end else if (strapWait_r != STRAP_SETTLE) begin
      strapWait_r <= strapWait_r + 2'h1;
      if (strapWait_r == STRAP_SETTLE - 2'h1) begin
        mode_r <= strapSync;
      end
    end
  end

  wire        teMode   = (mode_r == MODE_TE);
  wire        ntMode   = (mode_r == MODE_NT);
  wire        gen2     = interfaceModeSelect;
  // without the pin the line always counts as connected
  wire        connected = HAS_CONNECT_PIN ? connSync : 1'b1;

  // activation
  lbft_act_t actState_r;
  lbft_act_t actNxt;

  always_comb begin
    actNxt = actState_r;
    case (actState_r)
      ACT_IDLE: begin
        if (rxInfo2or4) begin
          actNxt = ACT_UP;
        end else if (activateRequest && connected) begin
          actNxt = ACT_INFO1;
        end
      end
      ACT_INFO1: begin
        if (rxInfo2or4) begin
          actNxt = ACT_UP;
        end else if (!connected) begin
          actNxt = ACT_IDLE;
        end
      end
      ACT_UP: begin
        if (!rxInfo2or4) begin
          actNxt = ACT_IDLE;
        end
      end
      default: actNxt = ACT_IDLE;
    endcase
  end

  wire discNxt = HAS_CONNECT_PIN && !connSync && strapWait_r[1];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      actState_r           <= ACT_IDLE;
      sendInfo1            <= 1'b0;
      activated            <= 1'b0;
      disconnectIndication <= 1'b0;
      operatingMode        <= MODE_TE;
    end else begin
      actState_r           <= actNxt;
      sendInfo1            <= (actNxt == ACT_INFO1);
      activated            <= (actNxt == ACT_UP);
      disconnectIndication <= discNxt;
      operatingMode        <= mode_r;
    end
  end

  // auxiliary serial ports follow bus generation and timing mode
  wire ppEnNxt  = !gen2;
  wire ppMstNxt = !gen2 && !serialPortTimingSelect;
  wire syncPortEnNxt = !gen2 && !serialPortTimingSelect;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pingPongEnable <= 1'b0;
      pingPongMaster <= 1'b0;
      syncPortEnable <= 1'b0;
    end else begin
      pingPongEnable <= ppEnNxt;
      pingPongMaster <= ppMstNxt;
      syncPortEnable <= syncPortEnNxt;
    end
  end

  // NT line test zeros; continuous request wins over single
  logic [12:0] zeroCnt_r;
  wire         zeroCont   = ntMode && zeroSync[1];
  wire         zeroSingle = ntMode && zeroSync[0] && !zeroSync[1];
  wire [12:0]  zeroLast   = zeroCont ? 13'(ZERO_CONT_CYCLES - 1) : 13'(SINGLE_ZERO_CYCLES - 1);
  wire         zeroWrap   = (zeroCnt_r >= zeroLast);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      zeroCnt_r       <= '0;
      sendZerosActive <= 1'b0;
      sendZeroStrobe  <= 1'b0;
    end else begin
      zeroCnt_r       <= (!(zeroCont || zeroSingle) || zeroWrap) ? 13'h0000 : zeroCnt_r + 13'h0001;
      sendZerosActive <= zeroCont || zeroSingle;
      sendZeroStrobe  <= (zeroCont || zeroSingle) && zeroWrap;
    end
  end

  // outgoing frame word assembly
  wire [7:0] monBase = (monitorEnable || arbitrationAccess) ? monitorTxData : IDLE_OCTET;
  logic [7:0] monOut;
  always_comb begin
    monOut = monBase;
    monOut[STOPGO_IDX] = dChannelStopGo;
  end

  lbft_tx_t txWord;
  assign txWord.b1    = (b1RouteSelect == 2'h0) ? IDLE_OCTET : b1TxData;
  assign txWord.b2    = (b2RouteSelect == 2'h0) ? IDLE_OCTET : b2TxData;
  assign txWord.mon   = monOut;
  assign txWord.d     = dTxBits;
  assign txWord.ci    = discNxt ? CI_DISCONNECT : ciTxCode;
  assign txWord.echoE = echoBitsIn;
  assign txWord.mBit  = multiframeBitIn;
  assign txWord.upD   = upDTxBits;
  assign txWord.upCi  = upCiTxCode;

  // word handshake towards the link: hold stays put until the link echoes the toggle
  lbft_tx_t txHold_r;
  logic     txReq_r;
  logic     txAckSync;
  logic     rxReqSync;
  logic     rxSeen_r;
  lbft_rx_t rxHold_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txHold_r <= '1;
      txReq_r  <= 1'b0;
    end else if (txAckSync == txReq_r) begin
      txHold_r <= txWord;
      txReq_r  <= ~txReq_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxSeen_r     <= 1'b0;
      rxFrame      <= '1;
      rxFrameValid <= 1'b0;
    end else begin
      rxFrameValid <= (rxReqSync != rxSeen_r);
      if (rxReqSync != rxSeen_r) begin
        rxFrame  <= rxHold_r;
        rxSeen_r <= rxReqSync;
      end
    end
  end

  // ---------------- link domain ----------------
  logic linkRstN;
  lbft_sync #(.WIDTH(1)) uLinkRst (
    .clk   (busDataClock),
    .rst_n (reset_n),
    .d     (1'b1),
    .q     (linkRstN)
  );

  lbft_cfg_t cfgSys;
  lbft_cfg_t cfgLink;
  assign cfgSys.mode       = mode_r;
  assign cfgSys.gen2       = interfaceModeSelect;
  assign cfgSys.timingSel  = serialPortTimingSelect;
  assign cfgSys.fsPolarity = frameSyncPolarity;

  lbft_sync #(.WIDTH($bits(lbft_cfg_t))) uCfgSync (
    .clk   (busDataClock),
    .rst_n (linkRstN),
    .d     (cfgSys),
    .q     (cfgLink)
  );

  logic txReqSync;
  logic txSeen_r;
  logic rxReq_r;
  logic rxAckSync;

  lbft_sync #(.WIDTH(2)) uToLink (
    .clk   (busDataClock),
    .rst_n (linkRstN),
    .d     ({txReq_r, rxSeen_r}),
    .q     ({txReqSync, rxAckSync})
  );
  lbft_sync #(.WIDTH(2)) uToSys (
    .clk   (clk_sys),
    .rst_n (reset_n),
    .d     ({txSeen_r, rxReq_r}),
    .q     ({txAckSync, rxReqSync})
  );

  wire lkTe   = (cfgLink.mode == MODE_TE);
  wire lkLtt  = (cfgLink.mode == MODE_LTT);
  wire lkNt   = (cfgLink.mode == MODE_NT);
  wire lkGen2 = cfgLink.gen2;
  wire lkTm1  = !lkGen2 && cfgLink.timingSel;

  // channels per frame; every channel takes 64 data clocks
  wire [3:0] nCh = (lkGen2 && !lkNt) ? (cfgLink.timingSel ? CH_NONTERM : CH_TERMINAL)
                                     : CH_GEN1;
  wire [9:0] clksPerFrame = 10'(nCh * CLKS_PER_CH);
  wire [8:0] frameLast    = 9'(clksPerFrame - 10'h001);
  wire [8:0] frameHalf    = 9'(clksPerFrame >> 1);

  logic [8:0] clkCnt_r;
  logic [8:0] fs1Cnt_r;
  logic       fs1Prev_r;
  logic       fs2Prev_r;

  // in timing mode 1, except in TE, the frame comes from the looped-back delayed sync
  wire fsSrc      = lkTm1 ? frameSyncTwoIn : frameSyncOneIn;
  wire fsSrcPrev  = lkTm1 ? fs2Prev_r : fs1Prev_r;
  wire fs1Edge    = frameSyncOneIn && !fs1Prev_r;
  wire frameStart = lkTe ? (clkCnt_r == frameLast) : (fsSrc && !fsSrcPrev);

  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      clkCnt_r  <= '0;
      fs1Cnt_r  <= '1;
      fs1Prev_r <= 1'b0;
      fs2Prev_r <= 1'b0;
    end else begin
      clkCnt_r  <= frameStart ? 9'h000 : clkCnt_r + 9'h001;
      fs1Cnt_r  <= fs1Edge ? 9'h000 : ((fs1Cnt_r == 9'h1FF) ? fs1Cnt_r : fs1Cnt_r + 9'h001);
      fs1Prev_r <= frameSyncOneIn;
      fs2Prev_r <= frameSyncTwoIn;
    end
  end

  // word latch from the system side, one frame word at a time
  lbft_tx_t txLink_r;
  logic [31:0] rxShift_r;
  lbft_rx_t    rxGot;
  assign rxGot = lbft_rx_t'(rxShift_r[30:1]);

  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      txSeen_r <= 1'b0;
      txLink_r <= '1;
    end else if (txReqSync != txSeen_r) begin
      txLink_r <= txHold_r;
      txSeen_r <= txReqSync;
    end
  end

  wire [7:0] bitIdx = clkCnt_r[8:1];
  wire       inCh0  = (bitIdx < 8'h20);
  wire [4:0] bitPos = bitIdx[4:0];
  wire       evenClk = !clkCnt_r[0];

  // T bit unused and E bit idle, both sent as ones
  wire [31:0] dsBits = {txLink_r.b1, txLink_r.b2, txLink_r.mon, txLink_r.d, txLink_r.ci, 2'b11};
  wire [31:0] usBits = {IDLE_OCTET, IDLE_OCTET, IDLE_OCTET, txLink_r.upD, txLink_r.upCi, 2'b11};
  wire        dsBit  = dsBits[5'd31 - bitPos];
  wire        usBit  = usBits[5'd31 - bitPos];
  wire        echoBit = (bitPos == ECHO_POS_HI) ? txLink_r.echoE[1] :
                        (bitPos == ECHO_POS_LO) ? txLink_r.echoE[0] :
                        (bitPos == MBIT_POS)    ? txLink_r.mBit : 1'b1;
  wire        rxDone = inCh0 && (bitPos == 5'h1F) && !evenClk;

  // data lines change on even clocks and are sampled on odd ones
  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      downstreamOut <= 1'b1;
      downstreamOe  <= 1'b0;
      upstreamOut   <= 1'b0;
      upstreamOe    <= 1'b0;
      echoOut       <= 1'b1;
      echoOe        <= 1'b0;
    end else begin
      if (evenClk) begin
        downstreamOut <= inCh0 ? dsBit : 1'b1;
        downstreamOe  <= inCh0;
        upstreamOe    <= inCh0 && !usBit;
        echoOut       <= inCh0 ? echoBit : 1'b1;
      end
      upstreamOut <= 1'b0;
      echoOe      <= lkTe;
    end
  end

  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      rxShift_r <= '1;
      rxReq_r   <= 1'b0;
      rxHold_r  <= '1;
    end else begin
      if (inCh0 && !evenClk) begin
        rxShift_r <= {rxShift_r[30:0], upstreamIn};
      end
      // a frame is dropped if the system side has not taken the previous one
      if (rxDone && (rxAckSync == rxReq_r)) begin
        rxHold_r <= rxGot;
        rxReq_r  <= ~rxReq_r;
      end
    end
  end

  // TE generates symmetric syncs, each with its own polarity
  wire fsLevel = (clkCnt_r < frameHalf);

  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      frameSyncOneOut  <= 1'b0;
      frameSyncTwoOut  <= 1'b0;
      frameSyncOe      <= 1'b0;
      busClockOe       <= 1'b0;
      downstreamPullup <= 1'b0;
      upstreamPullup   <= 1'b0;
    end else begin
      frameSyncOneOut  <= fsLevel ^ cfgLink.fsPolarity[0];
      frameSyncTwoOut  <= fsLevel ^ cfgLink.fsPolarity[1];
      frameSyncOe      <= lkTe;
      busClockOe       <= lkTe;
      downstreamPullup <= lkTe && lkGen2;
      upstreamPullup   <= lkTe && lkGen2;
    end
  end

  // aux clock divided from the bus clock, so it stays locked to the line
  logic [3:0] auxCnt_r;
  wire        auxEn   = lkGen2 && (lkTe || lkLtt);
  wire [3:0]  auxHalf = lkTe ? AUX_TE2_HALF : AUX_LTT2_HALF;
  wire        auxWrap = (auxCnt_r >= auxHalf - 4'h1);

  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      auxCnt_r    <= '0;
      auxClockOut <= 1'b0;
      auxClockOe  <= 1'b0;
    end else begin
      auxCnt_r    <= (!auxEn || auxWrap) ? 4'h0 : auxCnt_r + 4'h1;
      auxClockOut <= auxEn && (auxWrap ? !auxClockOut : auxClockOut);
      auxClockOe  <= auxEn;
    end
  end

  // shared pin: 128 kHz port clock in mode 0, delayed frame sync in mode 1
  wire portAClkLevel = clkCnt_r[PORT_A_CLK_BIT];
  wire dlySyncLevel  = (fs1Cnt_r >= DLY_SYNC_START) &&
                       (fs1Cnt_r < DLY_SYNC_START + DLY_SYNC_WIDTH);

  always_ff @(posedge busDataClock or negedge linkRstN) begin
    if (!linkRstN) begin
      serialPortAOut <= 1'b0;
      serialPortAOe  <= 1'b0;
    end else begin
      serialPortAOut <= !lkGen2 && (lkTm1 ? dlySyncLevel : portAClkLevel);
      serialPortAOe  <= !lkGen2;
    end
  end

endmodule // lbft_frame_timing
`default_nettype wire

/* File: verification/lbft_frame_timing_assertions.sv */
// bound checker for the layer bus frame timing block
`timescale 1ns/100ps
`default_nettype none
module lbft_frame_timing_assertions
  import lbft_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // causes
  input wire logic       sBusConnectedIn,
  input wire logic       interfaceModeSelect,
  input wire logic       serialPortTimingSelect,
  input wire logic       activateRequest,
  input wire logic       rxInfo2or4,
  // effects
  input wire logic [1:0] operatingMode,
  input wire logic       sendInfo1,
  input wire logic       activated,
  input wire logic       disconnectIndication,
  input wire logic       sendZerosActive,
  input wire logic       sendZeroStrobe,
  input wire logic       pingPongEnable,
  input wire logic       pingPongMaster,
  input wire logic       syncPortEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_refuse; $rose(sendInfo1) |-> $past(activateRequest) && !disconnectIndication; endproperty
  a_refuse: assert property (p_refuse) else $error("info1 without accepted request");
  property p_net; rxInfo2or4 |=> activated; endproperty
  a_net: assert property (p_net) else $error("network activation ignored");
  // four cycles of steady pin cover the synchroniser lag
  property p_act; sBusConnectedIn[*4] ##0 (activateRequest && !rxInfo2or4 && !sendInfo1
    && !activated) |=> sendInfo1; endproperty
  a_act: assert property (p_act) else $error("request not answered by info1");
  property p_disc; $stable(sBusConnectedIn)[*4] |-> disconnectIndication == !sBusConnectedIn;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect flag wrong");
  property p_gen2; interfaceModeSelect[*2] |-> !pingPongEnable && !syncPortEnable; endproperty
  a_gen2: assert property (p_gen2) else $error("serial ports alive on gen2 bus");
  property p_tm0; (!interfaceModeSelect && !serialPortTimingSelect)[*5]
    |-> pingPongEnable && pingPongMaster && syncPortEnable; endproperty
  a_tm0: assert property (p_tm0) else $error("timing mode 0 ports wrong");
  property p_tm1; (!interfaceModeSelect && serialPortTimingSelect)[*5]
    |-> !pingPongMaster && !syncPortEnable; endproperty
  a_tm1: assert property (p_tm1) else $error("timing mode 1 ports wrong");
  property p_zero; operatingMode != MODE_NT |-> !(sendZerosActive || sendZeroStrobe); endproperty
  a_zero: assert property (p_zero) else $error("zeros outside NT");
endmodule // lbft_frame_timing_assertions
bind lbft_frame_timing lbft_frame_timing_assertions lbft_frame_timing_assertions_inst (.*);
`default_nettype wire

/* File: verification/lbft_far_end.sv */
// far end of the bus: sync source, upstream sender, downstream capture
`timescale 1ns/100ps
`default_nettype none
module lbft_far_end (
  // link clock and reset
  input  wire logic        busDataClock,
  input  wire logic        reset_n,
  // block pins
  input  wire logic        downstreamOut,
  input  wire logic        downstreamOe,
  input  wire logic        echoOut,
  output logic             frameSync,
  output logic             upstreamDrive,
  // bench side
  input  wire logic [31:0] upWord,
  output logic [31:0]      downWord,
  output logic [31:0]      echoWord
);
  logic [5:0]  n;
  logic [31:0] sh;
  logic [31:0] es;
  // one sync for both inputs, 64 data clocks a frame
  always_ff @(posedge busDataClock or negedge reset_n) begin
    if (!reset_n) begin
      n <= 6'h3F;
      frameSync <= 1'b0;
      upstreamDrive <= 1'b1;
    end else begin
      n <= n + 6'h01;
      frameSync <= (n + 6'h01) < 6'h20;
      // each bit held two clocks so either sampling phase sees it
      upstreamDrive <= upWord[~n[5:1]];
    end
  end
  // block frame trails n by one clock: bit b stands at n = 2b+2, last bit at n = 0
  always_ff @(posedge busDataClock) begin
    if (downstreamOe && !n[0]) begin
      sh <= {sh[30:0], downstreamOut};
      es <= {es[30:0], echoOut};
    end
    if (downstreamOe && n == 6'h00) begin
      downWord <= {sh[30:0], downstreamOut};
      echoWord <= {es[30:0], echoOut};
    end
  end
endmodule // lbft_far_end
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the layer bus frame timing block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lbft_pkg::*;
  logic clk_sys = 1'b0;
  logic busDataClock = 1'b0;
  logic reset_n, modeStrapHigh, modeStrapLow, sBusConnectedIn, sendContZerosIn;
  logic sendSingleZerosIn, interfaceModeSelect, serialPortTimingSelect, activateRequest;
  logic rxInfo2or4, monitorEnable, arbitrationAccess, dChannelStopGo;
  logic [1:0] frameSyncPolarity, b1RouteSelect, b2RouteSelect;
  lbft_tx_t tx;
  logic [31:0] upWord;
  wire logic [31:0] downWord, echoWord;
  wire logic [1:0] operatingMode;
  wire logic sendInfo1, activated, disconnectIndication, sendZerosActive, sendZeroStrobe;
  wire logic pingPongEnable, pingPongMaster, syncPortEnable, rxFrameValid, busClockOe;
  wire logic frameSyncOe, downstreamOut, downstreamOe, upstreamOe, auxClockOe, frameSyncOneIn;
  wire logic upstreamDrive, echoOut;
  wire lbft_rx_t rxFrame;
  wire logic frameSyncTwoIn = frameSyncOneIn;
  // wired-and with pull-up, both ends may pull low
  wire logic upstreamIn = upstreamDrive & ~upstreamOe;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  lbft_frame_timing #(.SINGLE_ZERO_CYCLES(20)) lbft_frame_timing_inst (
    .*, .b1TxData(tx.b1), .b2TxData(tx.b2), .monitorTxData(tx.mon), .dTxBits(tx.d),
    .ciTxCode(tx.ci), .echoBitsIn(tx.echoE), .multiframeBitIn(tx.mBit), .upDTxBits(tx.upD),
    .upCiTxCode(tx.upCi), .frameSyncOneOut(), .frameSyncTwoOut(), .upstreamOut(),
    .echoOe(), .auxClockOut(), .serialPortAOut(), .serialPortAOe(), .downstreamPullup(),
    .upstreamPullup());
  lbft_far_end lbft_far_end_inst (.busDataClock, .reset_n, .downstreamOut, .downstreamOe,
    .echoOut, .frameSync(frameSyncOneIn), .upstreamDrive, .upWord, .downWord, .echoWord);
  always #50 clk_sys = ~clk_sys;
  initial begin
    #37;
    forever #80 busDataClock = ~busDataClock;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      summarize();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic restart(input logic [1:0] m);
    reset_n = 1'b0;
    {modeStrapHigh, modeStrapLow} = m;
    step(16);
    reset_n = 1'b1;
    step(12);
    check(operatingMode, m);
  endtask
  // measures cycles between two strobes
  task automatic period(input int exp);
    int c;
    repeat (300) if (sendZeroStrobe !== 1'b1) step(1);
    step(1);
    for (c = 1; c < 300 && sendZeroStrobe !== 1'b1; c++) step(1);
    check(32'(c), 32'(exp));
  endtask
  function automatic logic [31:0] expDown();
    logic [7:0] m;
    m = (monitorEnable | arbitrationAccess) ? tx.mon : 8'hFF;
    m[STOPGO_IDX] = dChannelStopGo;
    return {(b1RouteSelect != 2'h0) ? tx.b1 : 8'hFF, (b2RouteSelect != 2'h0) ? tx.b2 : 8'hFF,
            m, tx.d, tx.ci, 2'h3};
  endfunction
  initial begin
    {modeStrapHigh, modeStrapLow, sendContZerosIn, sendSingleZerosIn, activateRequest} = '0;
    {interfaceModeSelect, serialPortTimingSelect, rxInfo2or4, arbitrationAccess} = '0;
    {monitorEnable, dChannelStopGo, frameSyncPolarity, b1RouteSelect, b2RouteSelect} = '0;
    reset_n = 1'b0;
    sBusConnectedIn = 1'b1;
    tx = '0;
    upWord = '0;
    void'($urandom(86));
    restart(MODE_LTS);
    // first pass keeps every route and monitor source idle
    for (int i = 0; i < 6; i++) begin
      tx = lbft_tx_t'(39'({$urandom, $urandom}));
      {b1RouteSelect, b2RouteSelect, monitorEnable, arbitrationAccess} = 6'(i ? $urandom : 0);
      {dChannelStopGo, serialPortTimingSelect, frameSyncPolarity} = 4'($urandom);
      upWord = $urandom;
      step(450);
      check(downWord, expDown());
      check(echoWord, {24'hFF_FFFF, tx.echoE, tx.mBit, 5'h1F});
      check(32'(rxFrame), 32'(upWord[31:2] & {24'hFF_FFFF, tx.upD, tx.upCi}));
    end
    {interfaceModeSelect, serialPortTimingSelect} = 2'h2; // terminal timing for TE
    restart(MODE_TE);
    check({busClockOe, frameSyncOe, auxClockOe, pingPongEnable}, 4'hE);
    sBusConnectedIn = 1'b0;
    step(4);
    activateRequest = 1'b1;
    step(4);
    check({disconnectIndication, sendInfo1}, 2'h2);
    rxInfo2or4 = 1'b1;
    step(2);
    check(activated, 1'b1);
    {activateRequest, rxInfo2or4, sBusConnectedIn} = 3'h1;
    step(5);
    activateRequest = 1'b1;
    step(1);
    check({disconnectIndication, sendInfo1}, 2'h1);
    activateRequest = 1'b0;
    interfaceModeSelect = 1'b0;
    restart(MODE_NT);
    sendContZerosIn = 1'b1;
    step(6);
    check(sendZerosActive, 1'b1);
    period(ZERO_CONT_CYCLES);
    {sendContZerosIn, sendSingleZerosIn} = 2'h1;
    step(6);
    period(20);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
